// ---- rtl/dcff_pkg.sv ----
// Package of constants shared by the flag-control buffer files.
package dcff_pkg;
    localparam int          DCFF_WIDTH         = 18;
    localparam int          DCFF_DEPTH         = 64;
    localparam int          DCFF_OFS_W         = 12;
    localparam logic [11:0] DCFF_EMPTY_OFS_RST = 12'h007;
    localparam logic [11:0] DCFF_FULL_OFS_RST  = 12'h007;
    localparam int          DCFF_CLK_NS        = 40;
    localparam int          DCFF_RTR_NS        = 12;
    localparam int          DCFF_RTR_CYC       = (DCFF_RTR_NS + DCFF_CLK_NS - 1) / DCFF_CLK_NS;
    localparam logic [31:0] DCFF_ADDR_CTRL     = 32'h0000_0000;
    localparam logic [31:0] DCFF_ADDR_STAT     = 32'h0000_0004;
    localparam logic [31:0] DCFF_ADDR_MASK     = 32'h0000_0008;
    localparam logic [31:0] DCFF_ADDR_LEVEL    = 32'h0000_000C;
    localparam logic [31:0] DCFF_ADDR_EOFS     = 32'h0000_0010;
    localparam logic [31:0] DCFF_ADDR_FOFS     = 32'h0000_0014;
    localparam int          DCFF_NEV           = 4;
    localparam int          DCFF_EV_FULL       = 0;
    localparam int          DCFF_EV_EMPTY      = 1;
    localparam int          DCFF_EV_WCASC      = 2;
    localparam int          DCFF_EV_RCASC      = 3;
endpackage : dcff_pkg

// ---- rtl/dcff_flag_if.sv ----
// Interface carrying the count and offset view between the core and the flag decoder.
`timescale 1ns/1ps
interface dcff_flag_if #(parameter int AW = 7);
    logic [AW-1:0] count;
    logic [11:0]   empty_ofs;
    logic [11:0]   full_ofs;
    logic          full_n;
    logic          empty_n;
    logic          almost_empty_n;
    logic          almost_full_n;
    logic          half_full_n;
    modport core (output count, output empty_ofs, output full_ofs,
                  input full_n, input empty_n, input almost_empty_n,
                  input almost_full_n, input half_full_n);
    modport dec  (input count, input empty_ofs, input full_ofs,
                  output full_n, output empty_n, output almost_empty_n,
                  output almost_full_n, output half_full_n);
endinterface : dcff_flag_if

// ---- rtl/dcff_flag_dec.sv ----
// Combinational decode of the stored count into the five active-low flags.
`timescale 1ns/1ps
module dcff_flag_dec
    import dcff_pkg::*;
#(
    parameter int DEPTH = 64,
    parameter int AW    = 7
)(
    dcff_flag_if.dec f
);
    logic [12:0] cnt;
    always_comb
    begin
        cnt              = 13'(f.count);
        f.empty_n        = (cnt != 13'h0000);
        f.full_n         = (cnt != 13'(DEPTH));
        f.almost_empty_n = (cnt > {1'b0, f.empty_ofs});
        f.almost_full_n  = (cnt < 13'(DEPTH) - {1'b0, f.full_ofs});
        f.half_full_n    = (cnt <= 13'(DEPTH / 2));
    end
endmodule : dcff_flag_dec

// ---- rtl/dcff_top.sv ----
// Single-clock flag-control buffer with offset programming, rewind and Avalon-MM status.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module dcff_top
    import dcff_pkg::*;
#(
    parameter int DEPTH = DCFF_DEPTH,
    parameter int AW    = $clog2(DEPTH) + 1
)(
    // Clock and reset
    input  wire logic                  MCLK,
    input  wire logic                  RESET,
    // Producer side
    input  wire logic                  WRITE_EN_N,
    input  wire logic [DCFF_WIDTH-1:0] WRITE_DATA,
    input  wire logic                  OFFSET_LOAD_N,
    // Consumer side
    input  wire logic                  READ_EN_N,
    input  wire logic                  OUTPUT_EN_N,
    input  wire logic                  REWIND_PULSE,
    output logic      [DCFF_WIDTH-1:0] READ_DATA_O,
    output logic      [DCFF_WIDTH-1:0] READ_DATA_OE,
    // Flags
    output logic                       EMPTY_FLAG_N,
    output logic                       FULL_FLAG_N,
    output logic                       ALMOST_EMPTY_FLAG_N,
    output logic                       ALMOST_FULL_FLAG_N,
    output logic                       HALF_FULL_FLAG_N,
    output logic                       WRITE_CASCADE_OUT,
    output logic                       READ_CASCADE_OUT,
    // Avalon-MM slave
    input  wire logic [31:0]           AVS_ADDRESS,
    input  wire logic                  AVS_READ,
    input  wire logic                  AVS_WRITE,
    input  wire logic [31:0]           AVS_WRITEDATA,
    output logic      [31:0]           AVS_READDATA,
    output logic                       AVS_WAITREQUEST,
    output logic                       IRQ
);
    localparam int PW = AW - 1;

    // Inputs are synchronised because the producer and consumer sit outside this domain.
    logic [1:0] wen_s, ren_s, oe_s, rt_s, ld_s;
    logic [DCFF_WIDTH-1:0] wd_s1, wd_s2;
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            wen_s <= 2'h3;
            ren_s <= 2'h3;
            oe_s  <= 2'h3;
            rt_s  <= 2'h0;
            ld_s  <= 2'h3;
            wd_s1 <= '0;
            wd_s2 <= '0;
        end
        else
        begin
            wen_s <= {wen_s[0], WRITE_EN_N};
            ren_s <= {ren_s[0], READ_EN_N};
            oe_s  <= {oe_s[0], OUTPUT_EN_N};
            rt_s  <= {rt_s[0], REWIND_PULSE};
            ld_s  <= {ld_s[0], OFFSET_LOAD_N};
            wd_s1 <= WRITE_DATA;
            wd_s2 <= wd_s1;
        end
    end
    logic wen, ren, oe, ld, rt_d_r, rt_rise;
    assign wen     = !wen_s[1];
    assign ren     = !ren_s[1];
    assign oe      = !oe_s[1];
    assign ld      = !ld_s[1];
    assign rt_rise = rt_s[1] && !rt_d_r;

    logic [DCFF_WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW-1:0] cnt_r, cnt_nxt;
    logic [11:0]   eofs_r, eofs_nxt, fofs_r, fofs_nxt;
    logic          ofs_sel_r, ofs_sel_nxt;
    logic [DCFF_WIDTH-1:0] q_r, q_nxt;
    logic          wcas_r, wcas_nxt, rcas_r, rcas_nxt;
    logic [1:0]    rtr_r, rtr_nxt;
    logic          do_wr, do_rd;

    dcff_flag_if #(.AW(AW)) fi ();
    dcff_flag_dec #(.DEPTH(DEPTH), .AW(AW)) u_dec (.f(fi.dec));
    assign fi.count     = cnt_r;
    assign fi.empty_ofs = eofs_r;
    assign fi.full_ofs  = fofs_r;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    always_comb
    begin
        // The pin flag lags the count by one edge, so the live count gates as well;
        // otherwise a back-to-back burst would slip one word past a full or empty buffer.
        do_wr       = wen && !ld && FULL_FLAG_N && fi.full_n && (rtr_r == 2'h0);
        do_rd       = ren && !ld && EMPTY_FLAG_N && fi.empty_n && (rtr_r == 2'h0);
        wp_nxt      = wp_r;
        rp_nxt      = rp_r;
        cnt_nxt     = cnt_r;
        eofs_nxt    = eofs_r;
        fofs_nxt    = fofs_r;
        ofs_sel_nxt = ofs_sel_r;
        q_nxt       = q_r;
        wcas_nxt    = 1'b0;
        rcas_nxt    = 1'b0;
        rtr_nxt     = (rtr_r != 2'h0) ? rtr_r - 2'h1 : 2'h0;
        if (wen && ld)
        begin
            ofs_sel_nxt = !ofs_sel_r;
            if (!ofs_sel_r)
                eofs_nxt = wd_s2[11:0];
            else
                fofs_nxt = wd_s2[11:0];
        end
        if (ren && ld)
            q_nxt = DCFF_WIDTH'(ofs_sel_r ? fofs_r : eofs_r);
        if (do_wr)
        begin
            wp_nxt   = ptr_inc(wp_r);
            wcas_nxt = (wp_r == PW'(DEPTH - 1));
        end
        if (do_rd)
        begin
            q_nxt    = mem[rp_r];
            rp_nxt   = ptr_inc(rp_r);
            rcas_nxt = (rp_r == PW'(DEPTH - 1));
        end
        cnt_nxt = cnt_r + AW'(do_wr) - AW'(do_rd);
        if (rt_rise)
        begin
            rp_nxt  = '0;
            cnt_nxt = AW'(wp_r) + AW'(do_wr);
            if (wp_r == '0 && cnt_r != '0)
                cnt_nxt = AW'(DEPTH);
            rtr_nxt = 2'(DCFF_RTR_CYC);
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (do_wr)
            mem[wp_r] <= wd_s2;
    end

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            wp_r      <= '0;
            rp_r      <= '0;
            cnt_r     <= '0;
            eofs_r    <= DCFF_EMPTY_OFS_RST;
            fofs_r    <= DCFF_FULL_OFS_RST;
            ofs_sel_r <= 1'b0;
            q_r       <= '0;
            wcas_r    <= 1'b0;
            rcas_r    <= 1'b0;
            rtr_r     <= 2'h0;
            rt_d_r    <= 1'b0;
        end
        else
        begin
            wp_r      <= wp_nxt;
            rp_r      <= rp_nxt;
            cnt_r     <= cnt_nxt;
            eofs_r    <= eofs_nxt;
            fofs_r    <= fofs_nxt;
            ofs_sel_r <= ofs_sel_nxt;
            q_r       <= q_nxt;
            wcas_r    <= wcas_nxt;
            rcas_r    <= rcas_nxt;
            rtr_r     <= rtr_nxt;
            rt_d_r    <= rt_s[1];
        end
    end

    // Flags follow the count one edge after each transfer, which is the single-clock
    // form of the skew rules: both sides share MCLK, so there is always one edge apart.
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            EMPTY_FLAG_N        <= 1'b0;
            FULL_FLAG_N         <= 1'b1;
            ALMOST_EMPTY_FLAG_N <= 1'b0;
            ALMOST_FULL_FLAG_N  <= 1'b1;
            HALF_FULL_FLAG_N    <= 1'b1;
            READ_DATA_O         <= '0;
            READ_DATA_OE        <= '0;
            WRITE_CASCADE_OUT   <= 1'b0;
            READ_CASCADE_OUT    <= 1'b0;
        end
        else
        begin
            EMPTY_FLAG_N        <= fi.empty_n;
            FULL_FLAG_N         <= fi.full_n;
            ALMOST_EMPTY_FLAG_N <= fi.almost_empty_n;
            ALMOST_FULL_FLAG_N  <= fi.almost_full_n;
            HALF_FULL_FLAG_N    <= fi.half_full_n;
            READ_DATA_O         <= q_nxt;
            READ_DATA_OE        <= {DCFF_WIDTH{oe}};
            WRITE_CASCADE_OUT   <= wcas_nxt;
            READ_CASCADE_OUT    <= rcas_nxt;
        end
    end

    // Avalon-MM slave: one wait cycle, then the answer.
    // Writes commit only at the edge where the master sees waitrequest low.
    logic [DCFF_NEV-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
    logic                ctl_r, ctl_nxt, ack_r, ack_nxt, irq_nxt;
    logic [31:0]         rd_nxt;
    logic [DCFF_NEV-1:0] ev;
    logic                full_d_r, empty_d_r;
    assign ev = {rcas_r, wcas_r, !EMPTY_FLAG_N && empty_d_r, !FULL_FLAG_N && full_d_r};

    always_comb
    begin
        ack_nxt  = (AVS_READ || AVS_WRITE) && !ack_r;
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        ctl_nxt  = ctl_r;
        rd_nxt   = AVS_READDATA;
        if (ack_r && AVS_WRITE)
        begin
            if (AVS_ADDRESS == DCFF_ADDR_STAT)
                stat_nxt = stat_r & ~AVS_WRITEDATA[DCFF_NEV-1:0];
            if (AVS_ADDRESS == DCFF_ADDR_MASK)
                mask_nxt = AVS_WRITEDATA[DCFF_NEV-1:0];
            if (AVS_ADDRESS == DCFF_ADDR_CTRL)
                ctl_nxt = AVS_WRITEDATA[0];
        end
        stat_nxt = stat_nxt | (ev & {DCFF_NEV{ctl_r}});
        if (ack_nxt && AVS_READ)
        begin
            unique case (AVS_ADDRESS)
                DCFF_ADDR_CTRL:  rd_nxt = {31'h0, ctl_r};
                DCFF_ADDR_STAT:  rd_nxt = 32'(stat_r);
                DCFF_ADDR_MASK:  rd_nxt = 32'(mask_r);
                DCFF_ADDR_LEVEL: rd_nxt = 32'(cnt_r);
                DCFF_ADDR_EOFS:  rd_nxt = 32'(eofs_r);
                DCFF_ADDR_FOFS:  rd_nxt = 32'(fofs_r);
                default:         rd_nxt = 32'h0000_0000;
            endcase
        end
        irq_nxt = |(stat_nxt & ~mask_nxt);
    end

    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            stat_r          <= '0;
            mask_r          <= '0;
            ctl_r           <= 1'b1;
            ack_r           <= 1'b0;
            full_d_r        <= 1'b1;
            empty_d_r       <= 1'b0;
            AVS_READDATA    <= 32'h0000_0000;
            AVS_WAITREQUEST <= 1'b1;
            IRQ             <= 1'b0;
        end
        else
        begin
            stat_r          <= stat_nxt;
            mask_r          <= mask_nxt;
            ctl_r           <= ctl_nxt;
            ack_r           <= ack_nxt;
            full_d_r        <= FULL_FLAG_N;
            empty_d_r       <= EMPTY_FLAG_N;
            AVS_READDATA    <= rd_nxt;
            AVS_WAITREQUEST <= !ack_nxt;
            IRQ             <= irq_nxt;
        end
    end

    // Checks.
    AST_WR_BLOCK: assert property (@(posedge MCLK) disable iff (RESET)
        (!FULL_FLAG_N || cnt_r == AW'(DEPTH)) |=> (wp_r == $past(wp_r)))
        else $error("write taken while full");
    AST_RD_BLOCK: assert property (@(posedge MCLK) disable iff (RESET)
        ((!EMPTY_FLAG_N || cnt_r == '0) && !rt_rise) |=> (rp_r == $past(rp_r)))
        else $error("read taken while empty");
    AST_EMPTY_FLAG: assert property (@(posedge MCLK) disable iff (RESET)
        (cnt_r == '0) |=> !EMPTY_FLAG_N) else $error("empty flag wrong");
    AST_FULL_FLAG: assert property (@(posedge MCLK) disable iff (RESET)
        (cnt_r == AW'(DEPTH)) |=> !FULL_FLAG_N) else $error("full flag wrong");
    AST_AE: assert property (@(posedge MCLK) disable iff (RESET)
        (13'(cnt_r) <= {1'b0, eofs_r}) |=> !ALMOST_EMPTY_FLAG_N)
        else $error("almost empty wrong");
    AST_AF: assert property (@(posedge MCLK) disable iff (RESET)
        (13'(cnt_r) >= 13'(DEPTH) - {1'b0, fofs_r}) |=> !ALMOST_FULL_FLAG_N)
        else $error("almost full wrong");
    AST_RT: assert property (@(posedge MCLK) disable iff (RESET)
        rt_rise |=> (rp_r == '0)) else $error("rewind missed");
    AST_OFS: assert property (@(posedge MCLK) disable iff (RESET)
        (wen && ld && !ofs_sel_r) |=> (eofs_r == $past(wd_s2[11:0]) && ofs_sel_r))
        else $error("offset order wrong");
    AST_WCAS: assert property (@(posedge MCLK) disable iff (RESET)
        (do_wr && wp_r == PW'(DEPTH - 1)) |=> WRITE_CASCADE_OUT)
        else $error("cascade missing");
    COV_FULL: cover property (@(posedge MCLK) disable iff (RESET) !FULL_FLAG_N);
    COV_RT:   cover property (@(posedge MCLK) disable iff (RESET) rt_rise && cnt_r != '0);
    COV_IRQ:  cover property (@(posedge MCLK) disable iff (RESET) IRQ);
endmodule : dcff_top

// ---- test/dcff_partner.sv ----
// Producer and consumer model that drives the buffer's pin-level side.
`timescale 1ns/1ps
module dcff_partner
    import dcff_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Producer side
    output logic                       wr_en_n,
    output logic      [DCFF_WIDTH-1:0] wr_data,
    output logic                       ofs_load_n,
    // Consumer side
    output logic                       rd_en_n,
    output logic                       rewind
);
    initial
    begin
        wr_en_n    = 1'b1;
        wr_data    = '0;
        ofs_load_n = 1'b1;
        rd_en_n    = 1'b1;
        rewind     = 1'b0;
    end

    task automatic edge_out_of_reset();
        @(posedge clk);
        while (rst !== 1'b0)
            @(posedge clk);
    endtask : edge_out_of_reset

    task automatic push(input logic [DCFF_WIDTH-1:0] d);
        edge_out_of_reset();
        wr_en_n <= 1'b0;
        rd_en_n <= 1'b1;
        wr_data <= d;
    endtask : push

    task automatic pop();
        edge_out_of_reset();
        wr_en_n <= 1'b1;
        rd_en_n <= 1'b0;
        wr_data <= ~wr_data;
    endtask : pop

    // Released data lines keep toggling so a stale word never passes for a fresh one.
    task automatic idle();
        @(posedge clk);
        wr_en_n    <= 1'b1;
        rd_en_n    <= 1'b1;
        ofs_load_n <= 1'b1;
        wr_data    <= ~wr_data;
    endtask : idle

    task automatic load_ofs(input logic [11:0] d);
        edge_out_of_reset();
        ofs_load_n <= 1'b0;
        wr_en_n    <= 1'b0;
        wr_data    <= {6'h00, d};
        @(posedge clk);
        wr_en_n <= 1'b1;
        wr_data <= ~wr_data;
        // Load stays low one edge longer so the synchroniser cannot split it from the enable.
        @(posedge clk);
        ofs_load_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : load_ofs

    task automatic read_ofs();
        edge_out_of_reset();
        ofs_load_n <= 1'b0;
        rd_en_n    <= 1'b0;
        @(posedge clk);
        rd_en_n <= 1'b1;
        @(posedge clk);
        ofs_load_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : read_ofs

    task automatic rewind_go();
        edge_out_of_reset();
        rewind <= 1'b1;
        @(posedge clk);
        rewind <= 1'b0;
        repeat (DCFF_RTR_CYC + 6) @(posedge clk);
    endtask : rewind_go
endmodule : dcff_partner

// ---- test/tb_dual_clock_fifo_flag_control.sv ----
// Self-checking bench for the flag-control buffer.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb_dual_clock_fifo_flag_control
    import dcff_pkg::*;
;
    logic                  mclk = 1'b0;
    logic                  reset = 1'b1;
    logic                  oe_n = 1'b0;
    logic                  wen_n, ld_n, ren_n, rw;
    logic                  ef_n, ff_n, ae_n, af_n, hf_n, wco, rco, irq, waitreq;
    logic [DCFF_WIDTH-1:0] wd, rdat, rdat_oe, last;
    logic [31:0]           addr = '0, wdat = '0, rdata, rv;
    logic                  avr = 1'b0, avw = 1'b0;
    int                    err_total = 0, n_checks = 0, seed = 32'h567e, eo = 7, fo = 7;
    int                    n_wco = 0, n_rco = 0;
    logic [DCFF_WIDTH-1:0] q[$], h[$];

    dcff_top i_dcff_top (
        .MCLK(mclk), .RESET(reset), .WRITE_EN_N(wen_n), .WRITE_DATA(wd),
        .OFFSET_LOAD_N(ld_n), .READ_EN_N(ren_n), .OUTPUT_EN_N(oe_n), .REWIND_PULSE(rw),
        .READ_DATA_O(rdat), .READ_DATA_OE(rdat_oe), .EMPTY_FLAG_N(ef_n), .FULL_FLAG_N(ff_n),
        .ALMOST_EMPTY_FLAG_N(ae_n), .ALMOST_FULL_FLAG_N(af_n), .HALF_FULL_FLAG_N(hf_n),
        .WRITE_CASCADE_OUT(wco), .READ_CASCADE_OUT(rco), .AVS_ADDRESS(addr), .AVS_READ(avr),
        .AVS_WRITE(avw), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .IRQ(irq)
    );
    dcff_partner i_dcff_partner (.clk(mclk), .rst(reset), .wr_en_n(wen_n), .wr_data(wd),
        .ofs_load_n(ld_n), .rd_en_n(ren_n), .rewind(rw));

    // Each cascade pulse must span exactly one edge, so a stuck output counts once for every edge it stays high.
    always @(posedge mclk)
    begin
        if (wco === 1'b1)
            n_wco++;
        if (rco === 1'b1)
            n_rco++;
    end

    initial
    begin
        forever #20 mclk = ~mclk;
    end

    function automatic logic [4:0] exp_flags(int n);
        return {n != DCFF_DEPTH, n < DCFF_DEPTH - fo, n <= DCFF_DEPTH / 2, n > eo, n != 0};
    endfunction : exp_flags

    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    task automatic avs(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge mclk);
        addr <= a;
        wdat <= d;
        avw  <= wr;
        avr  <= ~wr;
        while (waitreq !== 1'b0)
            @(posedge mclk);
        r = rdata;
        avr <= 1'b0;
        avw <= 1'b0;
    endtask : avs

    task automatic settle_chk();
        repeat (6) @(posedge mclk);
        `CHK({ff_n, af_n, hf_n, ae_n, ef_n}, exp_flags(q.size()))
        avs(1'b0, DCFF_ADDR_LEVEL, '0, rv);
        `CHK(rv, 32'(q.size()))
    endtask : settle_chk

    // Writes beyond the depth are refused by the device, so the model drops them too.
    task automatic put();
        logic [DCFF_WIDTH-1:0] d;
        d = DCFF_WIDTH'($random(seed));
        if (q.size() < DCFF_DEPTH)
            q.push_back(d);
        i_dcff_partner.push(d);
    endtask : put

    task automatic get();
        i_dcff_partner.pop();
        if (q.size() > 0)
            last = q.pop_front();
    endtask : get

    initial
    begin
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK({rdat, rdat_oe}, {18'h00000, 18'h3FFFF})
        settle_chk();
        avs(1'b0, DCFF_ADDR_CTRL, '0, rv);
        `CHK(rv[0], 1'b1)
        avs(1'b1, DCFF_ADDR_EOFS, 32'hFFF, rv);
        avs(1'b0, DCFF_ADDR_EOFS, '0, rv);
        `CHK(rv[11:0], DCFF_EMPTY_OFS_RST)
        avs(1'b0, 32'h40, '0, rv);
        `CHK(rv, 32'h0)
        oe_n <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK(rdat_oe, 18'h00000)
        oe_n <= 1'b0;
        eo = 1 + $unsigned($random(seed)) % 8;
        fo = 1 + $unsigned($random(seed)) % 8;
        i_dcff_partner.load_ofs(12'(eo));
        i_dcff_partner.load_ofs(12'(fo));
        avs(1'b0, DCFF_ADDR_EOFS, '0, rv);
        `CHK(rv[11:0], 12'(eo))
        avs(1'b0, DCFF_ADDR_FOFS, '0, rv);
        `CHK(rv[11:0], 12'(fo))
        i_dcff_partner.read_ofs();
        `CHK(rdat, DCFF_WIDTH'(eo))
        repeat (4 + $unsigned($random(seed)) % 8) put();
        i_dcff_partner.idle();
        settle_chk();
        for (int i = 0; i < 66; i++)
        begin
            put();
            i_dcff_partner.idle();
            settle_chk();
        end
        avs(1'b0, DCFF_ADDR_STAT, '0, rv);
        `CHK({rv[DCFF_EV_WCASC], rv[DCFF_EV_FULL]}, 2'b11)
        avs(1'b1, DCFF_ADDR_MASK, '0, rv);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b1)
        avs(1'b1, DCFF_ADDR_MASK, 32'hF, rv);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        repeat (5) get();
        i_dcff_partner.idle();
        settle_chk();
        `CHK(rdat, last)
        avs(1'b1, DCFF_ADDR_STAT, 32'hF, rv);
        avs(1'b1, DCFF_ADDR_MASK, '0, rv);
        avs(1'b0, DCFF_ADDR_STAT, '0, rv);
        `CHK(rv, 32'h0)
        `CHK(irq, 1'b0)
        for (int i = 0; i < DCFF_DEPTH; i++)
        begin
            get();
            i_dcff_partner.idle();
            settle_chk();
            `CHK(rdat, last)
        end
        avs(1'b0, DCFF_ADDR_STAT, '0, rv);
        `CHK({rv[DCFF_EV_RCASC], rv[DCFF_EV_EMPTY]}, 2'b11)
        repeat (3) put();
        h = q;
        i_dcff_partner.idle();
        settle_chk();
        repeat (2) get();
        i_dcff_partner.idle();
        settle_chk();
        i_dcff_partner.rewind_go();
        q = h;
        settle_chk();
        get();
        i_dcff_partner.idle();
        settle_chk();
        `CHK(rdat, h[0])
        `CHK(n_wco, 1)
        `CHK(n_rco, 1)
        summarize();
    end

    // About 1,600 cycles are expected; the limit leaves a wide margin.
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_total++;
        summarize();
    end
endmodule : tb_dual_clock_fifo_flag_control
